// file: sfw_pkg.sv
// Constants and types for the SPI F-RAM write-latch and opcode decoder.
//==============================================================================
//==============================================================================
package sfw_pkg;
    localparam logic [7:0] OP_SET_LATCH   = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH   = 8'h04;
    localparam logic [7:0] OP_STATUS_RD   = 8'h05;
    localparam logic [7:0] OP_STATUS_WR   = 8'h01;
    localparam logic [7:0] OP_WRITE_MASK  = 8'hF7;
    localparam logic [7:0] OP_WRITE_BASE  = 8'h02;
    localparam logic [7:0] OP_READ_BASE   = 8'h03;
    localparam logic [7:0] OP_WRITE_HIGH  = 8'h0A;
    localparam int         OP_ABIT_POS    = 3;
    localparam int         ADDR_W         = 9;
    localparam int         ST_LATCH_BIT   = 1;
    localparam int         ST_PSEL_LO_BIT = 2;
    localparam int         ST_PSEL_HI_BIT = 3;
    localparam logic [7:0] STATUS_RESET   = 8'h00;
    localparam logic [3:0] BITCNT_LAST    = 4'h7;

    typedef enum logic [4:0] {
        SFW_IDLE   = 5'b00001,
        SFW_OPCODE = 5'b00010,
        SFW_ADDR   = 5'b00100,
        SFW_DATA   = 5'b01000,
        SFW_IGNORE = 5'b10000
    } sfw_state_e;

    typedef struct packed {
        logic cs_n;
        logic sck;
        logic mosi;
    } sfw_pins_s;

    typedef struct packed {
        logic       valid;
        logic [8:0] addr;
        logic [7:0] data;
    } sfw_wr_s;
endpackage

// file: sfw_sync.sv
// Two-flop synchroniser bank for the SPI pins.
`timescale 1ns/1ps
`default_nettype none
module sfw_sync #(
    parameter int WIDTH = 3
) (
    // Clock
    input  wire logic             sys_clk_i,
    // Data
    input  wire logic [WIDTH-1:0] async_i,
    output var  logic [WIDTH-1:0] sync_o
);
    initial begin
        if (WIDTH < 1) $error("sfw_sync: WIDTH must be positive.");
    end
    logic [WIDTH-1:0] stage1;
    always_ff @(posedge sys_clk_i) begin
        stage1 <= async_i;
        sync_o <= stage1;
    end
endmodule
`default_nettype wire

// file: sfw_core.sv
// SPI F-RAM command interpreter: write latch, status register, opcode decode.
`timescale 1ns/1ps
`default_nettype none
module sfw_core #(
    parameter bit SILICON_BUG = 1'b1
) (
    // Clock and reset
    input  wire logic             sys_clk_i,
    input  wire logic             srst_i,
    // SPI pins
    input  wire logic             cs_n_i,
    input  wire logic             sck_i,
    input  wire logic             mosi_i,
    output logic                  miso_o,
    output logic                  miso_oe_n_o,
    // Memory write port
    output sfw_pkg::sfw_wr_s      mem_wr_o,
    // Status view
    output logic [7:0]            status_o
);
    sfw_pkg::sfw_pins_s pins;
    logic [2:0]         pins_raw;
    assign pins_raw = {cs_n_i, sck_i, mosi_i};

    sfw_sync #(.WIDTH(3)) u_sync (
        .sys_clk_i (sys_clk_i),
        .async_i   (pins_raw),
        .sync_o    (pins)
    );

    //==========================================================================
    // Edge detection on the sampled pins
    //==========================================================================
    logic sck_q;
    logic cs_n_q;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            sck_q  <= 1'b0;
            cs_n_q <= 1'b1;
        end else begin
            sck_q  <= pins.sck;
            cs_n_q <= pins.cs_n;
        end
    end
    logic sck_rise;
    logic sck_fall;
    logic cs_start;
    logic cs_end;
    assign sck_rise = pins.sck & ~sck_q & ~pins.cs_n;
    assign sck_fall = ~pins.sck & sck_q & ~pins.cs_n;
    assign cs_start = ~pins.cs_n & cs_n_q;
    assign cs_end   = pins.cs_n & ~cs_n_q;

    //==========================================================================
    // Byte shifter
    //==========================================================================
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic       byte_done;
    assign next_shift = {shift[6:0], pins.mosi};
    assign byte_done  = sck_rise && (bit_cnt == sfw_pkg::BITCNT_LAST);
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cs_start) begin
            bit_cnt <= 4'h0;
            shift   <= 8'h00;
        end else if (sck_rise) begin
            shift   <= next_shift;
            bit_cnt <= byte_done ? 4'h0 : bit_cnt + 4'h1;
        end
    end

    //==========================================================================
    // Command state machine
    //==========================================================================
    sfw_pkg::sfw_state_e state;
    logic [7:0] opcode;
    logic [8:0] addr;
    logic       is_write;
    logic       is_read;
    logic       is_stwr;
    logic       is_strd;
    logic       did_write;
    logic       did_high_write;
    logic       latch;
    logic [1:0] psel;

    assign is_write = (opcode & sfw_pkg::OP_WRITE_MASK) == sfw_pkg::OP_WRITE_BASE;
    assign is_read  = (opcode & sfw_pkg::OP_WRITE_MASK) == sfw_pkg::OP_READ_BASE;
    assign is_stwr  = opcode == sfw_pkg::OP_STATUS_WR;
    assign is_strd  = opcode == sfw_pkg::OP_STATUS_RD;

    always_ff @(posedge sys_clk_i) begin
        if (srst_i || pins.cs_n) begin
            state <= sfw_pkg::SFW_IDLE;
        end else begin
            case (state)
                sfw_pkg::SFW_IDLE: begin
                    state <= sfw_pkg::SFW_OPCODE;
                end
                sfw_pkg::SFW_OPCODE: begin
                    if (byte_done) begin
                        if (((next_shift & sfw_pkg::OP_WRITE_MASK) == sfw_pkg::OP_WRITE_BASE) ||
                            ((next_shift & sfw_pkg::OP_WRITE_MASK) == sfw_pkg::OP_READ_BASE)) begin
                            state <= sfw_pkg::SFW_ADDR;
                        end else if (next_shift == sfw_pkg::OP_STATUS_WR ||
                                     next_shift == sfw_pkg::OP_STATUS_RD) begin
                            state <= sfw_pkg::SFW_DATA;
                        end else begin
                            state <= sfw_pkg::SFW_IGNORE;
                        end
                    end
                end
                sfw_pkg::SFW_ADDR: begin
                    if (byte_done) state <= sfw_pkg::SFW_DATA;
                end
                sfw_pkg::SFW_DATA: begin
                    if (byte_done && (is_stwr || is_strd)) state <= sfw_pkg::SFW_IGNORE;
                end
                sfw_pkg::SFW_IGNORE: begin
                    state <= sfw_pkg::SFW_IGNORE;
                end
                default: begin
                    state <= sfw_pkg::SFW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            opcode <= 8'h00;
        end else if (state == sfw_pkg::SFW_OPCODE && byte_done) begin
            opcode <= next_shift;
        end
    end

    // Address bit 8 comes from the opcode, the low byte from the address phase.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            addr <= 9'h000;
        end else if (state == sfw_pkg::SFW_ADDR && byte_done) begin
            addr <= {opcode[sfw_pkg::OP_ABIT_POS], next_shift};
        end else if (state == sfw_pkg::SFW_DATA && byte_done && is_write) begin
            addr <= addr + 9'h001;
        end
    end

    //==========================================================================
    // Memory write strobe; data only lands while the latch is set
    //==========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            mem_wr_o <= '0;
        end else begin
            mem_wr_o.valid <= state == sfw_pkg::SFW_DATA && byte_done && is_write && latch;
            mem_wr_o.addr  <= addr;
            mem_wr_o.data  <= next_shift;
        end
    end

    // Remember whether this frame did a write so the clear waits for chip select.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || cs_start) begin
            did_write      <= 1'b0;
            did_high_write <= 1'b0;
        end else if (state == sfw_pkg::SFW_DATA && byte_done && latch && (is_write || is_stwr)) begin
            did_write      <= 1'b1;
            did_high_write <= opcode == sfw_pkg::OP_WRITE_HIGH;
        end
    end

    //==========================================================================
    // Write-enable latch and protect selects
    //==========================================================================
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            latch <= 1'b0;
        end else if (state == sfw_pkg::SFW_OPCODE && byte_done && next_shift == sfw_pkg::OP_SET_LATCH) begin
            latch <= 1'b1;
        end else if (state == sfw_pkg::SFW_OPCODE && byte_done && next_shift == sfw_pkg::OP_CLR_LATCH) begin
            latch <= 1'b0;
        end else if (cs_end && did_write && !(SILICON_BUG && did_high_write)) begin
            latch <= 1'b0;
        end
    end

    // The latch bit in a status write is discarded; only the selects store.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            psel <= 2'b00;
        end else if (state == sfw_pkg::SFW_DATA && byte_done && is_stwr && latch) begin
            psel <= {next_shift[sfw_pkg::ST_PSEL_HI_BIT], next_shift[sfw_pkg::ST_PSEL_LO_BIT]};
        end
    end

    logic [7:0] status_now;
    always_comb begin
        status_now = sfw_pkg::STATUS_RESET;
        status_now[sfw_pkg::ST_LATCH_BIT]  = latch;
        status_now[sfw_pkg::ST_PSEL_LO_BIT] = psel[0];
        status_now[sfw_pkg::ST_PSEL_HI_BIT] = psel[1];
    end
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            status_o <= sfw_pkg::STATUS_RESET;
        end else begin
            status_o <= status_now;
        end
    end

    //==========================================================================
    // Status read output, shifted on the falling clock edge
    //==========================================================================
    // The whole status byte is loaded, because the falling edge that closes the
    // opcode byte already presents the top bit for the host's next rising edge.
    logic [7:0] out_sr;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || pins.cs_n) begin
            out_sr      <= 8'h00;
            miso_o      <= 1'b0;
            miso_oe_n_o <= 1'b1;
        end else if (state == sfw_pkg::SFW_OPCODE && byte_done && next_shift == sfw_pkg::OP_STATUS_RD) begin
            out_sr      <= status_now;
            miso_o      <= status_now[7];
            miso_oe_n_o <= 1'b0;
        end else if (sck_fall && !miso_oe_n_o) begin
            miso_o <= out_sr[7];
            out_sr <= {out_sr[6:0], 1'b0};
        end
    end

    //==========================================================================
    // Checks
    //==========================================================================
    chk_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        status_o[0] == 1'b0 && status_o[7:4] == 4'h0) else $error("Reserved status bits nonzero.");
    chk_latch_set: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == sfw_pkg::SFW_OPCODE && byte_done && next_shift == sfw_pkg::OP_SET_LATCH)
        |=> latch) else $error("Latch not set by set command.");
    chk_latch_clr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (state == sfw_pkg::SFW_OPCODE && byte_done && next_shift == sfw_pkg::OP_CLR_LATCH)
        |=> !latch) else $error("Latch not cleared by clear command.");
    chk_write_gated: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        mem_wr_o.valid |-> $past(latch)) else $error("Write without latch.");
    chk_clear_at_end: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (cs_end && did_write && !did_high_write && latch) |=> !latch) else $error("Latch kept after write.");
    chk_high_keeps: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        (SILICON_BUG && cs_end && did_write && did_high_write && latch) |=> latch)
        else $error("High write cleared latch.");
    chk_no_midframe: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ($fell(latch) && !pins.cs_n) |-> (opcode == sfw_pkg::OP_CLR_LATCH || shift == sfw_pkg::OP_CLR_LATCH))
        else $error("Latch cleared mid-frame.");
    chk_high_addr: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        mem_wr_o.valid && opcode == sfw_pkg::OP_WRITE_HIGH |-> mem_wr_o.addr[8]) else $error("Address bit 8 lost.");
    chk_status_mirror: assert property (@(posedge sys_clk_i) disable iff (srst_i)
        ##1 status_o[sfw_pkg::ST_LATCH_BIT] == $past(latch)) else $error("Status latch bit stale.");
    cov_high_write: cover property (@(posedge sys_clk_i) mem_wr_o.valid && mem_wr_o.addr[8]);
    cov_status_wr: cover property (@(posedge sys_clk_i) state == sfw_pkg::SFW_DATA && byte_done && is_stwr);
    cov_status_rd: cover property (@(posedge sys_clk_i) !miso_oe_n_o);
    cov_high_read: cover property (@(posedge sys_clk_i) state == sfw_pkg::SFW_DATA && is_read && addr[8]);
endmodule
`default_nettype wire

// file: sfw_host_model.sv
// Behavioural SPI host for the write-latch block, driving chip select, clock and serial input in mode 0.
`timescale 1ns/1ps
`default_nettype none
module sfw_host_model (
    // Clock
    input  wire logic         sys_clk_i,
    // Serial answer from the block
    input  wire logic         miso_i,
    input  wire logic         miso_oe_n_i,
    // SPI pins towards the block
    output var sfw_pkg::sfw_pins_s pins_o
);
    initial begin
        pins_o = '{cs_n: 1'b1, sck: 1'b0, mosi: 1'b1};
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask

    // =====================================================================
    // Byte transfer
    // A bit read while the output is not enabled comes back unknown, so a
    // silent block can never pass for a correct answer.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            pins_o.mosi <= tx[i];
            wait_clk(4);
            pins_o.sck <= 1'b1;
            rx[i] = (miso_oe_n_i === 1'b0) ? miso_i : 1'bx;
            wait_clk(4);
            pins_o.sck <= 1'b0;
        end
        wait_clk(4);
    endtask

    // =====================================================================
    // Frames
    // The serial input is flipped on release so a stale level is never read.
    task automatic close();
        pins_o.cs_n <= 1'b1;
        pins_o.mosi <= ~pins_o.mosi;
        wait_clk(8);
    endtask

    task automatic frame(input logic [23:0] bytes, input int n, input bit keep_open, output logic [7:0] rx);
        pins_o.cs_n <= 1'b0;
        wait_clk(4);
        for (int k = 0; k < n; k++) begin
            xfer(bytes[23-8*k -: 8], rx);
        end
        if (!keep_open) begin
            close();
        end
    endtask

    task automatic write_safe(input logic [8:0] addr, input logic [7:0] data);
        logic [7:0] rx;
        frame({sfw_pkg::OP_WRITE_BASE | {4'h0, addr[8], 3'h0}, addr[7:0], data}, 3, 1'b0, rx);
        frame({sfw_pkg::OP_CLR_LATCH, 16'h0000}, 1, 1'b0, rx);
    endtask
endmodule
`default_nettype wire

// file: spi_fram_write_latch_opcode_tb.sv
// Self-checking testbench for the write-latch and opcode decoder.
`timescale 1ns/1ps
`default_nettype none
module spi_fram_write_latch_opcode_tb;
    logic               sys_clk_i   = 1'b0;
    logic               srst_i      = 1'b1;
    sfw_pkg::sfw_pins_s pins;
    logic               miso;
    logic               miso_oe_n;
    sfw_pkg::sfw_wr_s   mem_wr;
    sfw_pkg::sfw_wr_s   last_wr     = '0;
    logic [7:0]         status;
    logic [7:0]         wr_n        = 8'h00;
    logic [7:0]         rx;
    int                 n_fail      = 0;
    int                 comparisons = 0;

    always #20 sys_clk_i = ~sys_clk_i;

    sfw_core #(.SILICON_BUG(1'b1)) dut (
        .sys_clk_i   (sys_clk_i),
        .srst_i      (srst_i),
        .cs_n_i      (pins.cs_n),
        .sck_i       (pins.sck),
        .mosi_i      (pins.mosi),
        .miso_o      (miso),
        .miso_oe_n_o (miso_oe_n),
        .mem_wr_o    (mem_wr),
        .status_o    (status)
    );

    sfw_host_model host (
        .sys_clk_i   (sys_clk_i),
        .miso_i      (miso),
        .miso_oe_n_i (miso_oe_n),
        .pins_o      (pins)
    );

    always @(posedge sys_clk_i) begin
        if (mem_wr.valid === 1'b1) begin
            last_wr <= mem_wr;
            wr_n    <= wr_n + 8'h01;
        end
    end

    // =====================================================================
    // Compare and closing tasks
    task automatic check_st(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_wr(input logic [7:0] n_exp, input logic [8:0] addr, input logic [7:0] data);
        sfw_pkg::sfw_wr_s exp;
        exp = '{valid: 1'b1, addr: addr, data: data};
        check_st("write_count", n_exp, wr_n);
        comparisons++;
        if (last_wr !== exp) begin
            n_fail++;
            $display("[ERR] write_record expected %h seen %h", exp, last_wr);
        end
    endtask

    task automatic stop_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic set_latch();
        host.frame({sfw_pkg::OP_SET_LATCH, 16'h0000}, 1, 1'b0, rx);
    endtask

    // =====================================================================
    // Test sequence
    initial begin
        repeat (3) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        repeat (6) @(posedge sys_clk_i);
        check_st("status", sfw_pkg::STATUS_RESET, status);
        host.frame({sfw_pkg::OP_WRITE_BASE, 8'h34, 8'hA5}, 3, 1'b0, rx);
        check_st("write_count", 8'h00, wr_n);
        set_latch();
        check_st("status", 8'h02, status);
        host.frame({sfw_pkg::OP_STATUS_RD, 16'h0000}, 2, 1'b0, rx);
        check_st("status_read", 8'h02, rx);
        host.frame({sfw_pkg::OP_WRITE_BASE, 8'h34, 8'hA5}, 3, 1'b1, rx);
        check_wr(8'h01, 9'h034, 8'hA5);
        host.xfer(8'h5A, rx);
        check_wr(8'h02, 9'h035, 8'h5A);
        check_st("status", 8'h02, status);
        host.close();
        check_st("status", 8'h00, status);
        set_latch();
        host.frame({sfw_pkg::OP_WRITE_HIGH, 8'h10, 8'h3C}, 3, 1'b0, rx);
        check_wr(8'h03, 9'h110, 8'h3C);
        check_st("status", 8'h02, status);
        host.frame({sfw_pkg::OP_WRITE_BASE, 8'hFF, 8'hC3}, 3, 1'b0, rx);
        check_wr(8'h04, 9'h0FF, 8'hC3);
        check_st("status", 8'h00, status);
        set_latch();
        host.frame({sfw_pkg::OP_CLR_LATCH, 16'h0000}, 1, 1'b0, rx);
        check_st("status", 8'h00, status);
        host.frame({sfw_pkg::OP_WRITE_HIGH, 8'h20, 8'h11}, 3, 1'b0, rx);
        check_st("write_count", 8'h04, wr_n);
        set_latch();
        host.frame({sfw_pkg::OP_STATUS_WR, 8'hFF, 8'h00}, 2, 1'b1, rx);
        check_st("status", 8'h0E, status);
        host.close();
        check_st("status", 8'h0C, status);
        host.frame({sfw_pkg::OP_STATUS_WR, 8'h00, 8'h00}, 2, 1'b0, rx);
        check_st("status", 8'h0C, status);
        set_latch();
        host.frame({sfw_pkg::OP_STATUS_WR, 8'h02, 8'h00}, 2, 1'b0, rx);
        check_st("status", 8'h00, status);
        set_latch();
        host.frame({sfw_pkg::OP_READ_BASE | 8'h08, 8'h40, 8'h00}, 3, 1'b0, rx);
        check_st("write_count", 8'h04, wr_n);
        check_st("status", 8'h02, status);
        host.write_safe(9'h1AB, 8'h96);
        check_wr(8'h05, 9'h1AB, 8'h96);
        check_st("status", 8'h00, status);
        stop_test();
    end

    // Roughly eighteen times the expected length of the sequence.
    initial begin
        repeat (50000) @(posedge sys_clk_i);
        n_fail++;
        stop_test();
    end
endmodule
`default_nettype wire
